/* File: include/mebc_pkg.sv */
// package for the expanded bus controller: modes, states, reset values
// assumes a single 100 MHz clock domain and a synchronous reset
`default_nettype none
package mebc_pkg;
   localparam logic [1:0]  MODE_EXP_FULL   = 2'h1; // low and high address
   localparam logic [1:0]  MODE_EXP_LOW    = 2'h2; // low address only
   localparam logic [1:0]  MODE_SINGLE     = 2'h3;
   localparam logic [15:0] ADDR_IDLE       = 16'hFFFF;
   localparam logic        ENABLE_AT_RESET = 1'h1;
   localparam logic        PIN_EN_AT_RESET = 1'h0;
   localparam logic        MASK_AT_RESET   = 1'h1;
   localparam logic [1:0]  XTAL_HALF_DIV   = 2'h2; // crystal falls per phase
   localparam int          SYNC_STAGES     = 2;

   typedef enum logic [2:0] {
      ST_RESET  = 3'h0,
      ST_VECTOR = 3'h1,
      ST_RUN    = 3'h3,
      ST_STRETCH = 3'h2,
      ST_HALT   = 3'h6,
      ST_SLEEP  = 3'h7
   } mebc_state_t;
endpackage
`default_nettype wire

/* File: rtl/mebc_sync.sv */
// two flip-flop synchroniser for pins entering the clk domain
// assumes inputs are asynchronous levels
`default_nettype none
module mebc_sync
   import mebc_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else if (ce)
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // mebc_sync
`default_nettype wire

/* File: rtl/mebc_top.sv */
// expanded bus control: pin states, wait stretch, halt, opcode strobe
// assumes the core gives one access request per cycle with fetch marks
`default_nettype none
module mebc_top
   import mebc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [1:0]  mode,
   input  wire logic        crystal_clock_input,
   input  wire logic        wait_stretch_input,
   input  wire logic        halt_n,
   input  wire logic        port5_bit0,
   input  wire logic        wait_stretch_enable,
   input  wire logic        stop_request_enable,
   input  wire logic        internal_ram_enable,
   input  wire logic        ext_pin_interrupt_enable,
   input  wire logic        int_mask,
   input  wire logic        input_strobe_flag,
   input  wire logic        input_strobe_enable,
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic        acc_internal,
   input  wire logic        acc_int_ram,
   input  wire logic [15:0] acc_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic [7:0]  int_rdata,
   input  wire logic        acc_opcode,
   input  wire logic        acc_dummy,
   input  wire logic        instr_end,
   input  wire logic        sleep_until_irq_op,
   input  wire logic        irq_taken,
   input  wire logic [7:0]  data_in,
   output logic [15:0] addr_out,
   output logic [15:0] addr_oe_n,
   output logic [7:0]  data_out,
   output logic        data_oe_n,
   output logic        rd_n,
   output logic        wr_n,
   output logic        rw,
   output logic        strobe_oe_n,
   output logic        opcode_fetch_strobe,
   output logic        bus_available,
   output logic        bus_clock,
   output logic        int_clock,
   output logic        stall,
   output logic        int_write,
   output logic [7:0]  rdata,
   output logic        irq_request,
   output logic        wait_stretch_en_r,
   output logic        stop_request_en_r,
   output logic        pin_int_en_r,
   output logic        mask_r
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   // active-low pins enter inverted so a cleared synchroniser reads idle
   logic       xtal_s;
   logic       mr_low_s;
   logic       halt_low_s;
   logic       p50_low_s;
   mebc_sync #(.W(4)) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({crystal_clock_input, ~wait_stretch_input, ~halt_n,
             ~port5_bit0}),
      .q   ({xtal_s, mr_low_s, halt_low_s, p50_low_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // decode
   mebc_state_t state_r;
   mebc_state_t state_nxt;
   logic        xtal_d_r;
   logic [1:0]  div_r;
   logic        fetched_r;
   wire logic expanded   = (mode != MODE_SINGLE);
   wire logic xtal_fall  = xtal_d_r & ~xtal_s;
   wire logic phase_tick = xtal_fall & (div_r == XTAL_HALF_DIV - 2'h1);
   // ram disabled turns the internal ram range into an external access
   wire logic is_internal = acc_internal
                          & ~(acc_int_ram & ~internal_ram_enable);
   wire logic mr_active = expanded & wait_stretch_en_r
                        & ~is_internal & acc_valid & mr_low_s;
   wire logic halt_req  = expanded & stop_request_en_r & halt_low_s
                        & fetched_r;
   wire logic pin_irq   = pin_int_en_r & p50_low_s;
   wire logic strobe_irq = input_strobe_enable & input_strobe_flag;
   wire logic in_reset_st = (state_r == ST_RESET);

   ////////////////////////////////////////////////////////////////////////
   // state machine
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET:   state_nxt = ST_VECTOR;
         ST_VECTOR:
            if (acc_valid & acc_opcode)
               state_nxt = ST_RUN;
         ST_RUN:
            if (bus_clock & mr_active)
               state_nxt = ST_STRETCH;
            else if (halt_req & instr_end)
               state_nxt = ST_HALT;
            else if (sleep_until_irq_op)
               state_nxt = ST_SLEEP;
         ST_STRETCH:
            if (!mr_active)
               state_nxt = ST_RUN;
         ST_HALT:
            if (!halt_req)
               state_nxt = ST_RUN;
         ST_SLEEP:
            if (irq_request)
               state_nxt = ST_RUN;
         default:    state_nxt = ST_RESET;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // clock derivation: both clocks step on crystal falling edges only
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         xtal_d_r  <= 1'h0;
         div_r     <= 2'h0;
         int_clock <= 1'h0;
         bus_clock <= 1'h0;
      end
      else if (ce)
      begin
         xtal_d_r <= xtal_s;
         if (xtal_fall)
            div_r <= phase_tick ? 2'h0 : div_r + 2'h1;
         if (phase_tick)
            int_clock <= ~int_clock;
         // the external clock may not fall while stretched; rising is free
         if (phase_tick && !(bus_clock && state_nxt == ST_STRETCH))
            bus_clock <= ~bus_clock;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control bits and state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r           <= ST_RESET;
         fetched_r         <= 1'h0;
         wait_stretch_en_r <= ENABLE_AT_RESET;
         stop_request_en_r <= ENABLE_AT_RESET;
         pin_int_en_r      <= PIN_EN_AT_RESET;
         mask_r            <= MASK_AT_RESET;
      end
      else if (ce)
      begin
         state_r           <= state_nxt;
         if (state_r == ST_VECTOR && acc_valid && acc_opcode)
            fetched_r <= 1'h1;
         wait_stretch_en_r <= expanded & wait_stretch_enable;
         stop_request_en_r <= expanded & stop_request_enable;
         pin_int_en_r      <= ext_pin_interrupt_enable;
         mask_r            <= int_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus pins
   wire logic halted   = (state_r == ST_HALT);
   wire logic sleeping = (state_r == ST_SLEEP);
   wire logic drive    = acc_valid & ~sleeping & ~halted;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         addr_out            <= ADDR_IDLE;
         // reset drives the low address in modes 1, 2, the high in mode 1
         addr_oe_n           <= {{8{mode != MODE_EXP_FULL}},
                                 {8{mode == MODE_SINGLE}}};
         data_out            <= 8'h00;
         data_oe_n           <= 1'h1;
         rd_n                <= 1'h1;
         wr_n                <= 1'h1;
         rw                  <= 1'h1;
         strobe_oe_n         <= 1'h0;
         opcode_fetch_strobe <= 1'h1;
         bus_available       <= 1'h0;
         stall               <= 1'h1;
         int_write           <= 1'h0;
         rdata               <= 8'h00;
         irq_request         <= 1'h0;
      end
      else if (ce)
      begin
         // low address drives in modes 1 and 2, high address in mode 1
         addr_oe_n[7:0]  <= {8{~expanded}};
         addr_oe_n[15:8] <= {8{mode != MODE_EXP_FULL}};
         addr_out  <= (sleeping | ~drive) ? ADDR_IDLE : acc_addr;
         rd_n      <= ~(drive & ~acc_write);
         wr_n      <= ~(drive & acc_write);
         rw        <= ~(drive & acc_write);
         // in expanded modes writes drive data even when internal; reads release the bus
         data_oe_n <= ~(drive & acc_write & expanded);
         data_out  <= acc_wdata;
         int_write <= drive & acc_write & is_internal;
         rdata     <= is_internal ? int_rdata : data_in;
         strobe_oe_n   <= halted;
         bus_available <= halted;
         opcode_fetch_strobe <= ~(drive & acc_opcode & ~acc_dummy
                                  & ~in_reset_st);
         stall     <= (state_nxt != ST_RUN) & (state_nxt != ST_VECTOR);
         // one request line for both sources; irq_taken drops it a cycle
         irq_request <= ~mask_r & ~irq_taken
                      & (pin_irq | strobe_irq);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_RESET_EN: assert property (@(posedge clk)
      $rose(rst) |=> ##1 (wait_stretch_en_r && stop_request_en_r))
      else $error("enables not set by reset");
   AST_SINGLE: assert property (@(posedge clk) disable iff (rst)
      ce && mode == MODE_SINGLE && $past(mode) == MODE_SINGLE
      && state_r != ST_HALT |=> state_r != ST_HALT)
      else $error("halt in single chip mode");
   AST_INT_MR: assert property (@(posedge clk) disable iff (rst)
      ce && acc_internal && !acc_int_ram |-> !mr_active)
      else $error("stretch on internal access");
   AST_STROBES: assert property (@(posedge clk) disable iff (rst)
      ce && drive && acc_write |=> !wr_n && !rw)
      else $error("write strobe missing");
   AST_INT_WR_DATA: assert property (@(posedge clk) disable iff (rst)
      ce && drive && acc_write && expanded |=> !data_oe_n
      && data_out == $past(acc_wdata))
      else $error("internal write data not driven");
   AST_RD_FLOAT: assert property (@(posedge clk) disable iff (rst)
      ce && !acc_write |=> data_oe_n)
      else $error("data driven on read");
   AST_OVL_READ: assert property (@(posedge clk) disable iff (rst)
      ce && is_internal |=> rdata == $past(int_rdata))
      else $error("overlapped read took external data");
   AST_SLEEP_BUS: assert property (@(posedge clk) disable iff (rst)
      ce && state_r == ST_SLEEP |=> addr_out == ADDR_IDLE && rd_n
      && wr_n && rw && data_oe_n)
      else $error("bus not idle in sleep");
   AST_HALT_PINS: assert property (@(posedge clk) disable iff (rst)
      ce && state_r == ST_HALT |=> bus_available && strobe_oe_n)
      else $error("halt pins wrong");
   AST_IRQ_GATE: assert property (@(posedge clk) disable iff (rst)
      ce && mask_r |=> !irq_request)
      else $error("interrupt while masked");
   AST_DUMMY: assert property (@(posedge clk) disable iff (rst)
      ce && acc_dummy |=> opcode_fetch_strobe)
      else $error("strobe low on dummy fetch");
   // the stretch may end in the cycle the ready input returns
   AST_STRETCH: assert property (@(posedge clk) disable iff (rst)
      ce && state_r == ST_STRETCH && mr_active && bus_clock |=> bus_clock)
      else $error("bus clock fell while stretched");
   AST_RESET_PINS: assert property (@(posedge clk)
      rst |=> addr_out == ADDR_IDLE && data_oe_n && rd_n && wr_n && rw
      && opcode_fetch_strobe && !bus_available)
      else $error("pins not idle in reset");
   AST_EARLY_HALT: assert property (@(posedge clk) disable iff (rst)
      !fetched_r |=> state_r != ST_HALT)
      else $error("halt before first fetch");
   COV_STRETCH: cover property (@(posedge clk) state_r == ST_STRETCH);
   COV_HALT: cover property (@(posedge clk) state_r == ST_HALT);
   COV_SLEEP: cover property (@(posedge clk) state_r == ST_SLEEP);
   COV_IRQ: cover property (@(posedge clk) irq_request && !mask_r);
endmodule // mebc_top
`default_nettype wire

/* File: dv/mebc_ext_mem.sv */
// far-side model: external memory on the expanded bus
// assumes registered bus pins from the controller, one clk domain
`default_nettype none
module mebc_ext_mem
   import mebc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic [15:0] addr_out,
   input  wire logic [7:0]  data_out,
   input  wire logic        data_oe_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   output logic [7:0]  data_in,
   output logic        wait_stretch_input
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] last_r = 8'h5A;
   logic [4:0] hold_r = 5'h00;
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (!wr_n && !data_oe_n)
         mem[addr_out[7:0]] <= data_out;
      if (!rd_n)
         last_r <= mem[addr_out[7:0]];
      if (slow && !(rd_n && wr_n) && hold_r == 5'h00)
         hold_r <= 5'h14;
      else if (hold_r != 5'h00)
         hold_r <= hold_r - 5'h01;
   end
   // released bus shows the inverse so a stale value never passes
   assign data_in = !rd_n ? mem[addr_out[7:0]] : ~last_r;
   assign wait_stretch_input = (hold_r == 5'h00);
endmodule // mebc_ext_mem
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the expanded bus controller
// assumes mebc_top and the external memory model on its bus
`default_nettype none
`define CHK(nm, e, g) \
   begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module testbench
   import mebc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, rst = 1'h1, ce = 1'h1, slow = 1'h0, halt_n = 1'h1;
   logic [1:0] mode = 2'h1;
   logic crystal_clock_input = 1'h0, wait_stretch_input, port5_bit0 = 1'h1;
   logic wait_stretch_enable = 1'h0, stop_request_enable = 1'h0;
   logic internal_ram_enable = 1'h1, ext_pin_interrupt_enable = 1'h0;
   logic int_mask = 1'h1, input_strobe_flag = 1'h0, input_strobe_enable = 1'h0;
   logic acc_valid = 1'h0, acc_write = 1'h0, acc_internal = 1'h0;
   logic acc_int_ram = 1'h0, acc_opcode = 1'h0, acc_dummy = 1'h0;
   logic instr_end = 1'h0, sleep_until_irq_op = 1'h0, irq_taken = 1'h0;
   logic [15:0] acc_addr = 16'h0000, addr_out, addr_oe_n;
   logic [7:0] acc_wdata = 8'h00, int_rdata = 8'h00, data_in, data_out, rdata;
   logic data_oe_n, rd_n, wr_n, rw, strobe_oe_n, opcode_fetch_strobe;
   logic bus_available, bus_clock, int_clock, stall, int_write, irq_request;
   logic wait_stretch_en_r, stop_request_en_r, pin_int_en_r, mask_r;
   int err_count = 0, tests_run = 0, cyc = 0, hi_run = 0, hi_max = 0;
   int ic_tog = 0, t0, n;
   ////////////////////////////////////////////////////////////////////////
   mebc_top uut (.clk, .rst, .ce, .mode, .crystal_clock_input,
      .wait_stretch_input, .halt_n, .port5_bit0, .wait_stretch_enable,
      .stop_request_enable, .internal_ram_enable, .ext_pin_interrupt_enable,
      .int_mask, .input_strobe_flag, .input_strobe_enable, .acc_valid,
      .acc_write, .acc_internal, .acc_int_ram, .acc_addr, .acc_wdata,
      .int_rdata, .acc_opcode, .acc_dummy, .instr_end, .sleep_until_irq_op,
      .irq_taken, .data_in, .addr_out, .addr_oe_n, .data_out, .data_oe_n,
      .rd_n, .wr_n, .rw, .strobe_oe_n, .opcode_fetch_strobe, .bus_available,
      .bus_clock, .int_clock, .stall, .int_write, .rdata, .irq_request,
      .wait_stretch_en_r, .stop_request_en_r, .pin_int_en_r, .mask_r);
   mebc_ext_mem u_mem (.clk, .slow, .addr_out, .data_out, .data_oe_n,
      .rd_n, .wr_n, .data_in, .wait_stretch_input);
   ////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   // crystal toggles on clk falling edges, every 20 ns: one crystal cycle per four clk cycles
   always #20 crystal_clock_input = ~crystal_clock_input;
   always @(int_clock)
      ic_tog++;
   always @(posedge clk)
   begin
      cyc++;
      hi_run = bus_clock ? hi_run + 1 : 0;
      if (hi_run > hi_max)
         hi_max = hi_run;
      if (cyc == 30000)
      begin
         err_count++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // f holds write, internal, opcode, dummy
   task automatic acc(input logic [3:0] f, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      {acc_write, acc_internal, acc_opcode, acc_dummy} <= f;
      acc_valid <= 1'h1;
      acc_addr <= a;
      acc_wdata <= d;
      int_rdata <= d;
      @(posedge clk);
      acc_valid <= 1'h0;
      #1;
   endtask
   task automatic do_reset(input logic [1:0] m);
      @(posedge clk);
      rst <= 1'h1;
      mode <= m;
      wait_stretch_enable <= 1'h0;
      stop_request_enable <= 1'h0;
      repeat (10) @(posedge clk);
      #1;
      if (m != MODE_SINGLE)
         `CHK("en_rst", 2'h3, {wait_stretch_en_r, stop_request_en_r})
      `CHK("irq_rst", 2'h1, {pin_int_en_r, mask_r})
      `CHK("addr_rst", ADDR_IDLE, addr_out)
      `CHK("aoe_rst", {m == MODE_EXP_FULL ? 8'h00 : 8'hFF,
           m != MODE_SINGLE ? 8'h00 : 8'hFF}, addr_oe_n)
      `CHK("doe_rst", 1'h1, data_oe_n)
      @(posedge clk);
      rst <= 1'h0;
      wait_stretch_enable <= 1'h1;
      stop_request_enable <= 1'h1;
   endtask
   // the access stays pending: the far side stretches only while it is
   task automatic stretch_run(input logic [15:0] a, input logic i);
      @(posedge clk);
      slow <= 1'h1;
      {acc_write, acc_internal, acc_opcode, acc_dummy} <= {1'h0, i, 2'h0};
      acc_addr <= a;
      acc_valid <= 1'h1;
      hi_max = 0;
      t0 = ic_tog;
      repeat (40) @(posedge clk);
      acc_valid <= 1'h0;
      slow <= 1'h0;
      repeat (20) @(posedge clk);
      #1;
   endtask
   task automatic end_instr();
      repeat (4) @(posedge clk);
      instr_end <= 1'h1;
      @(posedge clk);
      instr_end <= 1'h0;
      repeat (6) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      for (n = 1; n <= 3; n++)
         do_reset(n[1:0]);
      do_reset(MODE_EXP_FULL);
      acc(4'h6, 16'hF000, 8'h00);
      `CHK("lir_op", 1'h0, opcode_fetch_strobe)
      acc(4'h7, 16'hF001, 8'h00);
      `CHK("lir_dmy", 1'h1, opcode_fetch_strobe)
      acc(4'h4, 16'hF002, 8'h00);
      `CHK("lir_dat", 1'h1, opcode_fetch_strobe)
      acc(4'hC, 16'h0040, 8'hA5);
      `CHK("wr_pins", 19'h00040, {wr_n, rw, addr_out})
      `CHK("wr_data", 9'h0A5, {data_oe_n, data_out})
      `CHK("int_wr", 1'h1, int_write)
      @(posedge clk);
      #1;
      `CHK("ext_mem", 8'hA5, u_mem.mem[8'h40])
      acc(4'h4, 16'h0040, 8'h3C);
      `CHK("rd_pins", 2'h1, {rd_n, rw})
      `CHK("rd_doe", 1'h1, data_oe_n)
      `CHK("rdata", 8'h3C, rdata)
      @(posedge clk);
      internal_ram_enable <= 1'h0;
      acc_int_ram <= 1'h1;
      acc(4'hC, 16'h0080, 8'h77);
      `CHK("ram_off", 3'h0, {int_write, data_oe_n, wr_n})
      @(posedge clk);
      internal_ram_enable <= 1'h1;
      acc_int_ram <= 1'h0;
      sleep_until_irq_op <= 1'h1;
      @(posedge clk);
      sleep_until_irq_op <= 1'h0;
      acc(4'hC, 16'h0050, 8'h5A);
      `CHK("slp_addr", ADDR_IDLE, addr_out)
      `CHK("slp_pins", 4'hF, {rd_n, wr_n, rw, data_oe_n})
      @(posedge clk);
      int_mask <= 1'h0;
      port5_bit0 <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
      `CHK("irq_off", 1'h0, irq_request)
      @(posedge clk);
      ext_pin_interrupt_enable <= 1'h1;
      for (n = 0; n < 10 && irq_request !== 1'h1; n++)
         @(posedge clk);
      #1;
      `CHK("irq_pin", 1'h1, irq_request)
      @(posedge clk);
      int_mask <= 1'h1;
      port5_bit0 <= 1'h1;
      ext_pin_interrupt_enable <= 1'h0;
      input_strobe_flag <= 1'h1;
      input_strobe_enable <= 1'h1;
      repeat (8) @(posedge clk);
      #1;
      `CHK("is_mask", 1'h0, irq_request)
      @(posedge clk);
      int_mask <= 1'h0;
      for (n = 0; n < 10 && irq_request !== 1'h1; n++)
         @(posedge clk);
      #1;
      `CHK("is_irq", 1'h1, irq_request)
      @(posedge clk);
      input_strobe_flag <= 1'h0;
      halt_n <= 1'h0;
      repeat (4) @(posedge clk);
      instr_end <= 1'h1;
      @(posedge clk);
      instr_end <= 1'h0;
      for (n = 0; n < 10 && bus_available !== 1'h1; n++)
         @(posedge clk);
      repeat (30) @(posedge clk);
      #1;
      `CHK("halt", 2'h3, {bus_available, strobe_oe_n})
      @(posedge clk);
      halt_n <= 1'h1;
      repeat (10) @(posedge clk);
      #1;
      `CHK("unhalt", 1'h0, bus_available)
      stretch_run(16'h8000, 1'h0);
      `CHK("stretch", 1'h1, hi_max > 10)
      `CHK("int_clk", 1'h1, ic_tog - t0 >= 4)
      stretch_run(16'h0040, 1'h1);
      `CHK("no_str_int", 1'h1, hi_max <= 8)
      @(posedge clk);
      halt_n <= 1'h0;
      do_reset(MODE_EXP_FULL);
      end_instr();
      #1;
      `CHK("halt_early", 1'h0, bus_available)
      acc(4'h6, 16'hF000, 8'h00);
      end_instr();
      #1;
      `CHK("halt_late", 1'h1, bus_available)
      `CHK("halt_stall", 1'h1, stall)
      @(posedge clk);
      halt_n <= 1'h1;
      do_reset(MODE_SINGLE);
      acc(4'h6, 16'hF000, 8'h00);
      stretch_run(16'h8000, 1'h0);
      `CHK("no_str_sc", 1'h1, hi_max <= 8)
      @(posedge clk);
      halt_n <= 1'h0;
      end_instr();
      repeat (10) @(posedge clk);
      #1;
      `CHK("no_halt_sc", 1'h0, bus_available)
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
